// ===== test_wpo_path_overhead.sv
`timescale 1ns/1ps
module test_wpo_path_overhead;
   // ====================================
   // stimulus and observed signals
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, srv = 1'b0;
   logic ce = 1'b1, pay = 1'b0, con = 1'b0, tick = 1'b0;
   logic [3:0] strb = 4'hF;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, rx_frame_valid, tx_frame_strobe, tx_oh_valid;
   logic rei_fifo_valid, rei_fifo_pop, irq_out_a, irq_out_b, e, v;
   logic [3:0] rei_fifo_count, c;
   logic [25:0] got;
   wpo_pkg::wpo_rx_oh_type rx_oh;
   wpo_pkg::wpo_tx_oh_type tx_oh;
   int fail_count = 0, total_checks = 0, seed = 32'h1687, n;
   always #5 pclk = ~pclk;
   // design under test, every input driven by the bench
   wpo_path_overhead i_dut (.pclk(pclk), .presetn(presetn), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_frame_valid(rx_frame_valid), .rx_oh(rx_oh),
      .tx_frame_strobe(tx_frame_strobe), .tx_oh(tx_oh),
      .tx_oh_valid(tx_oh_valid), .rei_fifo_valid(rei_fifo_valid),
      .rei_fifo_count(rei_fifo_count), .rei_fifo_pop(rei_fifo_pop),
      .local_server_defect(srv), .local_payload_defect(pay),
      .local_connectivity_defect(con), .stats_tick(tick),
      .irq_out_a(irq_out_a), .irq_out_b(irq_out_b));
   wpo_far_end i_far (.pclk(pclk), .tx_oh(tx_oh), .tx_oh_valid(tx_oh_valid),
      .rei_fifo_pop(rei_fifo_pop), .rx_frame_valid(rx_frame_valid),
      .rx_oh(rx_oh), .tx_frame_strobe(tx_frame_strobe),
      .rei_fifo_valid(rei_fifo_valid), .rei_fifo_count(rei_fifo_count));
   // compare one value, count it
   task chk(input logic [31:0] g, input logic [31:0] x);
      total_checks++;
      if (g !== x) begin
         fail_count++;
         $display("CHECK FAILED %0t got %h exp %h", $time, g, x);
      end
   endtask : chk
   // apb transfer; pready ends the wait, only the watchdog bounds it
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // model: status octet bits 7:1 = error count, defect code
   function int g1(int fv, int cnt, int sd, int cd, int pd);
      return (fv ? cnt : 0) * 8 + (sd ? 5 : (cd ? 6 : (pd ? 2 : 1)));
   endfunction : g1
   task report_and_stop;
      $display("checks %0d failures %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : report_and_stop
   // watchdog well past the expected run
   initial begin
      #500000;
      fail_count++;
      report_and_stop;
   end
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, wpo_pkg::OFS_CTRL, 32'h0);
      chk(r, wpo_pkg::CTRL_RESET);
      apb(1'b0, 8'h40, 32'h0);
      chk(e, 32'h1);
      $display("register test done");
      for (n = 0; n < 8; n++) begin
         c = 4'($unsigned($random(seed)) % 9);
         v = 1'($random(seed));
         srv <= 1'($random(seed));
         pay <= 1'($random(seed));
         con <= 1'($random(seed));
         i_far.tx(v, c, got);
         chk(got[25:24], {1'b1, v});
         chk(got[15:9], g1(v, c, srv, con, pay));
         chk(got[23:16], 8'h1A);
      end
      srv <= 1'b0;
      pay <= 1'b0;
      con <= 1'b0;
      $display("transmit test done");
      repeat (4) i_far.rx(16'h0002);
      apb(1'b0, wpo_pkg::OFS_STATUS, 32'h0);
      chk(r[0], 32'h0);
      i_far.rx(16'h0002);
      apb(1'b0, wpo_pkg::OFS_STATUS, 32'h0);
      chk(r[15:0], 32'h0001);
      apb(1'b1, wpo_pkg::OFS_MASKA, 32'h2);
      repeat (5) i_far.rx(16'h2202);
      repeat (3) @(posedge pclk);
      chk(irq_out_a, 32'h1);
      chk(irq_out_b, 32'h0);
      apb(1'b0, wpo_pkg::OFS_PEND, 32'h0);
      chk(r[1], 32'h1);
      i_far.tx(1'b0, 4'h0, got);
      chk(got[15:9], g1(0, 0, 0, 0, 1));
      i_far.rx(16'h2232);
      apb(1'b0, wpo_pkg::OFS_STD_CNT, 32'h0);
      chk(r, 32'h1);
      // server code: nine frames are not yet enough, the tenth is
      repeat (9) i_far.rx(16'h220A);
      apb(1'b0, wpo_pkg::OFS_STATUS, 32'h0);
      chk(r[4], 32'h0);
      i_far.rx(16'h220A);
      apb(1'b0, wpo_pkg::OFS_STATUS, 32'h0);
      chk(r[6:4], 32'h5);
      // a frame while frozen must leave every count alone
      ce <= 1'b0;
      i_far.rx(16'h2232);
      ce <= 1'b1;
      tick <= 1'b1;
      @(posedge pclk);
      tick <= 1'b0;
      apb(1'b0, wpo_pkg::OFS_STAT_CNT, 32'h0);
      chk(r, 32'h3);
      // upper lanes only: one-bit both ways, block mode on
      strb <= 4'hC;
      apb(1'b1, wpo_pkg::OFS_CTRL, 32'h0400_0000);
      strb <= 4'hF;
      i_far.rx(16'h2232);
      // payload code carries no bit-5 flag in one-bit mode
      repeat (10) i_far.rx(16'h2204);
      tick <= 1'b1;
      @(posedge pclk);
      tick <= 1'b0;
      apb(1'b0, wpo_pkg::OFS_STAT_CNT, 32'h0);
      chk(r, 32'h1);
      apb(1'b0, wpo_pkg::OFS_STATUS, 32'h0);
      chk(r[4], 32'h0);
      apb(1'b0, wpo_pkg::OFS_STD_CNT, 32'h0);
      chk(r, 32'h2);
      srv <= 1'b1;
      i_far.tx(1'b0, 4'h0, got);
      chk(got[15:8], 32'h08);
      $display("receive test done");
      report_and_stop;
   end
endmodule : test_wpo_path_overhead

// ===== wpo_far_end.sv
`timescale 1ns/1ps
// ====================================
// far end: sends frames, takes octets
module wpo_far_end (
   input wire logic pclk,
   input wire wpo_pkg::wpo_tx_oh_type tx_oh,
   input wire logic tx_oh_valid,
   input wire logic rei_fifo_pop,
   output logic rx_frame_valid,
   output wpo_pkg::wpo_rx_oh_type rx_oh,
   output logic tx_frame_strobe,
   output logic rei_fifo_valid,
   output logic [3:0] rei_fifo_count
);
   // idle values at time zero
   initial begin
      rx_frame_valid = 1'b0;
      rx_oh = 16'h0000;
      tx_frame_strobe = 1'b0;
      rei_fifo_valid = 1'b0;
      rei_fifo_count = 4'h0;
   end
   // one frame; octets inverted once released
   task rx(input logic [15:0] oh);
      @(posedge pclk);
      rx_frame_valid <= 1'b1;
      rx_oh <= oh;
      @(posedge pclk);
      rx_frame_valid <= 1'b0;
      rx_oh <= ~oh;
   endtask : rx
   // fifo count held until the pop edge
   task tx(input logic v, input logic [3:0] c, output logic [25:0] got);
      @(posedge pclk);
      tx_frame_strobe <= 1'b1;
      rei_fifo_valid <= v;
      rei_fifo_count <= c;
      @(posedge pclk);
      tx_frame_strobe <= 1'b0;
      @(posedge pclk);
      got = {tx_oh_valid, rei_fifo_pop, tx_oh};
      rei_fifo_valid <= 1'b0;
      rei_fifo_count <= ~c;
   endtask : tx
endmodule : wpo_far_end

// ===== wpo_path_overhead.sv
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module wpo_path_overhead #(
   parameter int STD_CNT_W = 16,
   parameter int STAT_CNT_W = 32
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_frame_valid,
   input wire wpo_pkg::wpo_rx_oh_type rx_oh,
   input wire logic tx_frame_strobe,
   output wpo_pkg::wpo_tx_oh_type tx_oh,
   output logic tx_oh_valid,
   input wire logic rei_fifo_valid,
   input wire logic [3:0] rei_fifo_count,
   output logic rei_fifo_pop,
   input wire logic local_server_defect,
   input wire logic local_payload_defect,
   input wire logic local_connectivity_defect,
   input wire logic stats_tick,
   output logic irq_out_a,
   output logic irq_out_b
);

   // ==========================================================
   // elaboration checks
   // ==========================================================
   if (STD_CNT_W < 4 || STD_CNT_W > 32 || STAT_CNT_W < 4 ||
       STAT_CNT_W > 32) begin : g_bad_width
      $error("counter widths must lie between 4 and 32");
   end

   // ==========================================================
   // helper functions
   // ==========================================================
   // byte-lane merge for register writes
   function automatic logic [31:0] lane_merge(input logic [31:0] old,
         input logic [31:0] wr, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = wr[i*8 +: 8];
         end
      end
      return r;
   endfunction : lane_merge

   // connectivity event shares the far-end defect mask bit
   function automatic logic [7:0] eff_mask(input logic [31:0] m);
      logic [7:0] r;
      r = m[7:0];
      r[wpo_pkg::EV_FCON] = m[wpo_pkg::EV_FDEF];
      return r;
   endfunction : eff_mask

   // received error count; counts above eight are meaningless
   function automatic logic [3:0] rei_of(input logic [7:0] g1);
      logic [3:0] v;
      v = g1[wpo_pkg::G1_REI_LSB +: 4];
      return (v > wpo_pkg::REI_MAX) ? 4'h0 : v;
   endfunction : rei_of

   // ==========================================================
   // state
   // ==========================================================
   logic [31:0] ctrl_q, ctrl_d;        // control word
   logic [31:0] maska_q, maska_d;      // mask toward output a
   logic [31:0] maskb_q, maskb_d;      // mask toward output b
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   logic [7:0] pend_q, pend_d;         // sticky events
   logic [7:0] latch_q, latch_d;       // latch-high status bits
   logic irq_a_q, irq_a_d;
   logic irq_b_q, irq_b_d;
   logic [7:0] cand_q, cand_d;         // label being qualified
   logic [2:0] cand_cnt_q, cand_cnt_d;
   logic [7:0] acc_label_q, acc_label_d;
   logic [3:0] def_cnt_q, def_cnt_d;   // persistence counter
   logic fdef_q, fdef_d;               // far-end defect live
   logic [2:0] last_code_q, last_code_d;
   logic [STD_CNT_W-1:0] std_cnt_q, std_cnt_d;
   logic [STAT_CNT_W-1:0] stat_acc_q, stat_acc_d;
   logic [STAT_CNT_W-1:0] stat_snap_q, stat_snap_d;
   wpo_pkg::wpo_tx_oh_type tx_oh_q, tx_oh_d;
   logic tx_valid_q, tx_valid_d;
   logic pop_q, pop_d;

   // live conditions from held state, event sets and bus strobes
   logic [7:0] live;
   logic mismatch_live;
   logic [7:0] ev_set;
   logic bus_done, rd_pend, rd_status;

   // ==========================================================
   // apb slave: answer in the first access cycle
   // ==========================================================
   assign bus_done = psel && penable && pready_q;
   assign rd_pend = bus_done && !pwrite && paddr == wpo_pkg::OFS_PEND;
   assign rd_status = bus_done && !pwrite &&
                      paddr == wpo_pkg::OFS_STATUS;

   // read data prepared in the setup cycle, registered
   always_comb begin
      ctrl_d = ctrl_q;
      maska_d = maska_q;
      maskb_d = maskb_q;
      prdata_d = prdata_q;
      pslverr_d = 1'b0;
      pready_d = 1'b0;
      if (psel && !penable) begin
         pready_d = 1'b1;
         prdata_d = 32'h0000_0000;
         // address decode
         if (paddr == wpo_pkg::OFS_CTRL) begin
            prdata_d = ctrl_q;
         end else if (paddr == wpo_pkg::OFS_STATUS) begin
            prdata_d[7:0] = live | latch_q;
            prdata_d[wpo_pkg::STATUS_LABEL_LSB +: 8] = acc_label_q;
         end else if (paddr == wpo_pkg::OFS_PEND) begin
            prdata_d[7:0] = pend_q;
         end else if (paddr == wpo_pkg::OFS_MASKA) begin
            prdata_d = maska_q;
         end else if (paddr == wpo_pkg::OFS_MASKB) begin
            prdata_d = maskb_q;
         end else if (paddr == wpo_pkg::OFS_STD_CNT) begin
            prdata_d[STD_CNT_W-1:0] = std_cnt_q;
         end else if (paddr == wpo_pkg::OFS_STAT_CNT) begin
            prdata_d[STAT_CNT_W-1:0] = stat_snap_q;
         end else begin
            // unmapped: error answer, zero data
            pslverr_d = 1'b1;
         end
      end else if (psel && penable && pready_q) begin
         pslverr_d = pslverr_q;
      end
      // writes land only at the completing edge
      if (bus_done && pwrite) begin
         if (paddr == wpo_pkg::OFS_CTRL) begin
            ctrl_d = lane_merge(ctrl_q, pwdata, pstrb);
         end else if (paddr == wpo_pkg::OFS_MASKA) begin
            // only the eight event bits (the low byte lane) are kept
            maska_d = lane_merge(maska_q, pwdata, pstrb) & 32'h0000_00FF;
         end else if (paddr == wpo_pkg::OFS_MASKB) begin
            maskb_d = lane_merge(maskb_q, pwdata, pstrb) & 32'h0000_00FF;
         end
      end
   end

   // bus registers; ctrl reset carries both label defaults
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= wpo_pkg::CTRL_RESET;
         maska_q <= 32'h0000_0000;
         maskb_q <= 32'h0000_0000;
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else if (ce) begin
         ctrl_q <= ctrl_d;
         maska_q <= maska_d;
         maskb_q <= maskb_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   // ==========================================================
   // receive side: label, defects, far-end counters
   // ==========================================================
   assign mismatch_live = acc_label_q != wpo_pkg::UNEQ_LABEL &&
      acc_label_q != ctrl_q[wpo_pkg::CTRL_EXP_LABEL_LSB +: 8];

   // live status view; latched bits are or-ed in on read
   always_comb begin
      live = 8'h00;
      live[wpo_pkg::EV_UNEQ] = acc_label_q == wpo_pkg::UNEQ_LABEL;
      live[wpo_pkg::EV_FERR] = |std_cnt_q;
      live[wpo_pkg::EV_STATNZ] = |stat_acc_q;
      live[wpo_pkg::EV_FDEF] = fdef_q;
      live[wpo_pkg::EV_FCON] = fdef_q && ctrl_q[wpo_pkg::CTRL_RX_ENH] &&
                               last_code_q == wpo_pkg::CODE_CONN;
   end

   // next receive state and event sets
   always_comb begin
      logic seen;
      logic [3:0] rei;
      logic [2:0] code;
      logic [STAT_CNT_W:0] sum;
      seen = 1'b0;
      rei = 4'h0;
      code = 3'h0;
      sum = '0;
      cand_d = cand_q;
      cand_cnt_d = cand_cnt_q;
      acc_label_d = acc_label_q;
      def_cnt_d = def_cnt_q;
      fdef_d = fdef_q;
      last_code_d = last_code_q;
      std_cnt_d = std_cnt_q;
      stat_acc_d = stat_acc_q;
      stat_snap_d = stat_snap_q;
      ev_set = 8'h00;
      if (rx_frame_valid) begin
         code = rx_oh.status[wpo_pkg::G1_CODE_LSB +: 3];
         rei = rei_of(rx_oh.status);
         if (rx_oh.label == cand_q) begin
            if (cand_cnt_q < wpo_pkg::ACCEPT_FRAMES) begin
               cand_cnt_d = cand_cnt_q + 3'h1;
            end
         end else begin
            cand_d = rx_oh.label;
            cand_cnt_d = 3'h1;
         end
         if (cand_cnt_d == wpo_pkg::ACCEPT_FRAMES) begin
            acc_label_d = cand_d;
         end
         if (ctrl_q[wpo_pkg::CTRL_RX_ENH]) begin
            seen = code == wpo_pkg::CODE_PAYLOAD ||
                   code == wpo_pkg::CODE_SERVER ||
                   code == wpo_pkg::CODE_CONN;
         end else begin
            // bit 5 alone, bit 8 ignored
            seen = rx_oh.status[wpo_pkg::G1_RDI_BIT];
         end
         last_code_d = code;
         // ten contiguous frames to change state
         if (seen != fdef_q) begin
            if (def_cnt_q == wpo_pkg::DEFECT_FRAMES - 4'h1) begin
               fdef_d = seen;
               def_cnt_d = 4'h0;
            end else begin
               def_cnt_d = def_cnt_q + 4'h1;
            end
         end else begin
            def_cnt_d = 4'h0;
         end
         if (rei != 4'h0) begin
            std_cnt_d = std_cnt_q + 1'b1;
            ev_set[wpo_pkg::EV_FERR] = 1'b1;
         end
         if (ctrl_q[wpo_pkg::CTRL_RX_ENH] &&
             code == wpo_pkg::CODE_PAYLOAD) begin
            ev_set[wpo_pkg::EV_FPAY] = 1'b1;
         end
         if (ctrl_q[wpo_pkg::CTRL_RX_ENH] &&
             code == wpo_pkg::CODE_SERVER) begin
            ev_set[wpo_pkg::EV_FSRV] = 1'b1;
         end
      end
      // tick snapshots then restarts the sum
      if (stats_tick) begin
         stat_snap_d = stat_acc_q;
         stat_acc_d = '0;
      end
      if (rx_frame_valid && rei != 4'h0) begin
         // block mode adds one per frame
         if (ctrl_q[wpo_pkg::CTRL_BLK_MODE]) begin
            sum = {1'b0, stat_acc_d} + 1'b1;
         end else begin
            sum = {1'b0, stat_acc_d} + {{(STAT_CNT_W - 3){1'b0}}, rei};
         end
         // saturate rather than wrap
         stat_acc_d = sum[STAT_CNT_W] ? '1 : sum[STAT_CNT_W-1:0];
         ev_set[wpo_pkg::EV_STATNZ] = 1'b1;
      end
      // unequipped raised on acceptance of zero
      ev_set[wpo_pkg::EV_UNEQ] = acc_label_d == wpo_pkg::UNEQ_LABEL &&
                                 acc_label_q != wpo_pkg::UNEQ_LABEL;
      ev_set[wpo_pkg::EV_MISMATCH] = mismatch_live;
      ev_set[wpo_pkg::EV_FDEF] = fdef_d && !fdef_q;
      ev_set[wpo_pkg::EV_FCON] = fdef_d && ctrl_q[wpo_pkg::CTRL_RX_ENH] &&
         last_code_d == wpo_pkg::CODE_CONN && !live[wpo_pkg::EV_FCON];
   end

   // sticky bits: an event in the clearing cycle wins
   always_comb begin
      logic [7:0] lmask;
      lmask = 8'h00;
      lmask[wpo_pkg::EV_MISMATCH] = 1'b1;
      lmask[wpo_pkg::EV_FPAY] = 1'b1;
      lmask[wpo_pkg::EV_FSRV] = 1'b1;
      // clear only what the read returned; later sets survive
      pend_d = (rd_pend ? pend_q & ~prdata_q[7:0] : pend_q) | ev_set;
      latch_d = ((rd_status ? latch_q & ~prdata_q[7:0] : latch_q) |
                 ev_set) & lmask;
      irq_a_d = |(pend_d & eff_mask(maska_q));
      irq_b_d = |(pend_d & eff_mask(maskb_q));
   end

   // receive registers; accepted label starts at expected
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cand_q <= wpo_pkg::LABEL_RESET;
         cand_cnt_q <= 3'h0;
         acc_label_q <= wpo_pkg::LABEL_RESET;
         def_cnt_q <= 4'h0;
         fdef_q <= 1'b0;
         last_code_q <= wpo_pkg::CODE_NONE;
         std_cnt_q <= '0;
         stat_acc_q <= '0;
         stat_snap_q <= '0;
         pend_q <= 8'h00;
         latch_q <= 8'h00;
         irq_a_q <= 1'b0;
         irq_b_q <= 1'b0;
      end else if (ce) begin
         cand_q <= cand_d;
         cand_cnt_q <= cand_cnt_d;
         acc_label_q <= acc_label_d;
         def_cnt_q <= def_cnt_d;
         fdef_q <= fdef_d;
         last_code_q <= last_code_d;
         std_cnt_q <= std_cnt_d;
         stat_acc_q <= stat_acc_d;
         stat_snap_q <= stat_snap_d;
         pend_q <= pend_d;
         latch_q <= latch_d;
         irq_a_q <= irq_a_d;
         irq_b_q <= irq_b_d;
      end
   end

   // ==========================================================
   // transmit side: overhead octets per frame strobe
   // ==========================================================
   always_comb begin
      logic [3:0] rei;
      logic [2:0] code;
      rei = 4'h0;
      code = wpo_pkg::CODE_NONE;
      tx_oh_d = tx_oh_q;
      tx_valid_d = 1'b0;
      pop_d = 1'b0;
      if (tx_frame_strobe) begin
         if (rei_fifo_valid) begin
            rei = rei_fifo_count;
            pop_d = 1'b1;
         end
         if (local_server_defect) begin
            code = wpo_pkg::CODE_SERVER;
         end else if (local_connectivity_defect ||
                      live[wpo_pkg::EV_UNEQ]) begin
            code = wpo_pkg::CODE_CONN;
         end else if (local_payload_defect || mismatch_live) begin
            code = wpo_pkg::CODE_PAYLOAD;
         end
         tx_oh_d.label = ctrl_q[wpo_pkg::CTRL_TX_LABEL_LSB +: 8];
         tx_oh_d.user = ctrl_q[wpo_pkg::CTRL_USER_LSB +: 8];
         tx_oh_d.status = 8'h00;
         // error count in the top nibble
         tx_oh_d.status[wpo_pkg::G1_REI_LSB +: 4] = rei;
         if (ctrl_q[wpo_pkg::CTRL_TX_ENH]) begin
            tx_oh_d.status[wpo_pkg::G1_CODE_LSB +: 3] = code;
         end else begin
            tx_oh_d.status[wpo_pkg::G1_RDI_BIT] = local_server_defect;
         end
         tx_valid_d = 1'b1;
      end
   end

   // transmit registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_oh_q <= '{wpo_pkg::LABEL_RESET, 8'h00, wpo_pkg::USER_RESET};
         tx_valid_q <= 1'b0;
         pop_q <= 1'b0;
      end else if (ce) begin
         tx_oh_q <= tx_oh_d;
         tx_valid_q <= tx_valid_d;
         pop_q <= pop_d;
      end
   end

   // outputs straight from flops
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign tx_oh = tx_oh_q;
   assign tx_oh_valid = tx_valid_q;
   assign rei_fifo_pop = pop_q;
   assign irq_out_a = irq_a_q;
   assign irq_out_b = irq_b_q;

   // ==========================================================
   // assertions
   // ==========================================================
   property p_label_accept;
      @(posedge pclk) disable iff (!presetn)
      ce && $changed(acc_label_q) |-> $past(rx_frame_valid) &&
         $past(cand_cnt_q) == wpo_pkg::ACCEPT_FRAMES - 3'h1;
   endproperty
   a_label_accept: assert property (p_label_accept)
      else $error("label accepted without five frames");

   property p_tx_label;
      @(posedge pclk) disable iff (!presetn)
      ce && tx_frame_strobe |=> tx_oh_valid &&
         tx_oh.label == $past(ctrl_q[7:0]);
   endproperty
   a_tx_label: assert property (p_tx_label)
      else $error("transmit label not from control");

   property p_tx_user;
      @(posedge pclk) disable iff (!presetn)
      ce && tx_frame_strobe |=> tx_oh.user == $past(ctrl_q[23:16]);
   endproperty
   a_tx_user: assert property (p_tx_user)
      else $error("user channel not from control");

   property p_no_count;
      @(posedge pclk) disable iff (!presetn)
      ce && tx_frame_strobe && !rei_fifo_valid |=>
         tx_oh.status[7:4] == 4'h0 && !rei_fifo_pop;
   endproperty
   a_no_count: assert property (p_no_count)
      else $error("nonzero count sent with empty fifo");

   property p_server_first;
      @(posedge pclk) disable iff (!presetn)
      ce && tx_frame_strobe && ctrl_q[25] && local_server_defect |=>
         tx_oh.status[3:1] == 3'h5;
   endproperty
   a_server_first: assert property (p_server_first)
      else $error("server code not given priority");

   property p_one_bit_tx;
      @(posedge pclk) disable iff (!presetn)
      ce && tx_frame_strobe && !ctrl_q[25] |=>
         tx_oh.status[2:0] == 3'h0;
   endproperty
   a_one_bit_tx: assert property (p_one_bit_tx)
      else $error("one-bit mode sent nonzero bits 6-8");

   property p_std_step;
      @(posedge pclk) disable iff (!presetn)
      $changed(std_cnt_q) |-> std_cnt_q == $past(std_cnt_q) + 1'b1;
   endproperty
   a_std_step: assert property (p_std_step)
      else $error("standard counter moved by other than one");

   property p_tick_snap;
      @(posedge pclk) disable iff (!presetn)
      ce && stats_tick |=> stat_snap_q == $past(stat_acc_q);
   endproperty
   a_tick_snap: assert property (p_tick_snap)
      else $error("tick did not snapshot the accumulator");

   property p_defect_declare;
      @(posedge pclk) disable iff (!presetn)
      $rose(fdef_q) |-> $past(def_cnt_q) == wpo_pkg::DEFECT_FRAMES - 4'h1
         ##1 pend_q[wpo_pkg::EV_FDEF] || $past(rd_pend);
   endproperty
   a_defect_declare: assert property (p_defect_declare)
      else $error("far defect declared too early or unflagged");

endmodule : wpo_path_overhead

// ===== wpo_pkg.sv
// ============================================================
// shared constants and carriers for the path overhead block
// ============================================================
package wpo_pkg;

   // ==========================================================
   // register byte offsets (one aligned word each)
   // ==========================================================
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_PEND = 8'h08;
   localparam logic [7:0] OFS_MASKA = 8'h0C;
   localparam logic [7:0] OFS_MASKB = 8'h10;
   localparam logic [7:0] OFS_STD_CNT = 8'h14;
   localparam logic [7:0] OFS_STAT_CNT = 8'h18;

   // ==========================================================
   // control word layout and reset values
   // ==========================================================
   localparam int CTRL_TX_LABEL_LSB = 0;
   localparam int CTRL_EXP_LABEL_LSB = 8;
   localparam int CTRL_USER_LSB = 16;
   localparam int CTRL_RX_ENH = 24;
   localparam int CTRL_TX_ENH = 25;
   localparam int CTRL_BLK_MODE = 26;
   localparam logic [7:0] LABEL_RESET = 8'h1A;
   localparam logic [7:0] USER_RESET = 8'h00;
   localparam logic [31:0] CTRL_RESET = 32'h0300_1A1A;
   localparam logic [7:0] UNEQ_LABEL = 8'h00;

   // ==========================================================
   // event bit positions in status, pending and mask words
   // ==========================================================
   localparam int EV_UNEQ = 0;
   localparam int EV_MISMATCH = 1;
   localparam int EV_FERR = 2;
   localparam int EV_STATNZ = 3;
   localparam int EV_FDEF = 4;
   localparam int EV_FPAY = 5;
   localparam int EV_FSRV = 6;
   localparam int EV_FCON = 7;
   localparam int NUM_EV = 8;
   localparam int STATUS_LABEL_LSB = 8;

   // ==========================================================
   // path status octet layout and defect codes
   // ==========================================================
   localparam int G1_REI_LSB = 4;
   localparam int G1_RDI_BIT = 3;
   localparam int G1_CODE_LSB = 1;
   localparam logic [2:0] CODE_NONE = 3'h1;
   localparam logic [2:0] CODE_PAYLOAD = 3'h2;
   localparam logic [2:0] CODE_SERVER = 3'h5;
   localparam logic [2:0] CODE_CONN = 3'h6;
   localparam logic [3:0] REI_MAX = 4'h8;
   localparam logic [2:0] ACCEPT_FRAMES = 3'h5;
   localparam logic [3:0] DEFECT_FRAMES = 4'hA;

   // received overhead octets of one frame
   typedef struct packed {
      logic [7:0] label;
      logic [7:0] status;
   } wpo_rx_oh_type;

   // transmitted overhead octets of one frame
   typedef struct packed {
      logic [7:0] label;
      logic [7:0] status;
      logic [7:0] user;
   } wpo_tx_oh_type;

endpackage : wpo_pkg
